// File: src/ubf_pkg.sv
package ubf_pkg;
    localparam int          SRAM_AW           = 15;
    localparam logic [15:0] TX_REGION_BYTES   = 16'h2000;
    localparam logic [15:0] RX_REGION_BYTES   = 16'h5000;
    localparam int          SRAM_BYTES        = int'(TX_REGION_BYTES) + int'(RX_REGION_BYTES);
    localparam logic [14:0] TX_BASE           = 15'h0000;
    localparam logic [14:0] RX_BASE           = TX_BASE + TX_REGION_BYTES[14:0];
    localparam logic [15:0] HS_BLOCK_BYTES    = 16'h0200;
    localparam logic [15:0] FS_BLOCK_BYTES    = 16'h0040;
    localparam int          MAC_TX_FIFO_BYTES = 2048;
    localparam int          MAC_RX_FIFO_BYTES = 128;
    localparam logic [1:0]  MAC_TX_MAX_FRAMES = 2'h2;
    localparam logic [15:0] HDR_BYTES         = 16'h0002;
    localparam logic [15:0] SLOT_BYTES        = HDR_BYTES + 16'h0001;
    localparam logic        MODE_MULTI        = 1'b0;
    localparam logic        MODE_SINGLE       = 1'b1;

    typedef enum logic [2:0] {PS_HDR0 = 3'h1, PS_HDR1 = 3'h2, PS_DATA = 3'h4} ubf_parse_type;
    typedef enum logic [2:0] {BI_IDLE = 3'h1, BI_SEND = 3'h2, BI_WAIT = 3'h4} ubf_pkt_type;
    typedef enum logic [2:0] {WR_DATA = 3'h1, WR_LEN_LO = 3'h2, WR_LEN_HI = 3'h4} ubf_wr_type;
endpackage

// File: src/ubf_fifo.sv
`timescale 1ns/1ps
module ubf_fifo
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
)(
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    output logic                  out_valid,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_ready_unused_n,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
        begin : g_bad_depth
            $error("ubf_fifo depth must be a power of two of at least 2");
        end
    endgenerate

    logic [WIDTH-1:0] store [0:DEPTH-1];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      level;

    wire logic push = in_valid && in_ready;
    wire logic pop  = out_valid && out_ready;

    assign in_ready           = level != (AW+1)'(DEPTH);
    assign out_valid          = level != '0;
    assign out_data           = store[rd_ptr];
    assign out_ready_unused_n = 1'b1;

    always_ff @(posedge clk)
    begin
        if (push)
            store[wr_ptr] <= in_data;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level  <= '0;
        end
        else
        begin
            if (push)
                wr_ptr <= wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= rd_ptr + 1'b1;
            level <= level + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// File: src/ubf_bulk_path.sv
// How it works
// - One SRAM array holds an 8 KB transmit region and a 20 KB receive region at fixed bases.
// - Bulk-out bytes go straight into the transmit region and an extractor cuts them into frames for the MAC.
// - Frames from the MAC side pass through the receive FIFO into the receive region and feed the bulk-in packets.
// - Bulk-in packets are cut into blocks of 512 bytes at high speed and 64 bytes at full speed.
// - A bulk-out packet flagged bad on its last byte is discarded by moving the write pointer back.
// - If the bulk-in handshake fails, the same packet is sent again from the still-buffered bytes.
// - The receive read head advances only after the host acknowledged the bulk-in packet.
// - Both directions carry either several length-prefixed frames per packet or one frame per packet.
// - The MAC side has independent transmit and receive paths carrying data plus last status, with bad status on the receive path only.
// - The MAC transmit FIFO holds 2 KB, releases only whole frames and never holds more than two.
// - Frames from the MAC enter through a 128-byte receive FIFO.
`timescale 1ns/1ps
module ubf_bulk_path
    import ubf_pkg::*;
#(
    parameter int TX_FIFO_DEPTH = MAC_TX_FIFO_BYTES,
    parameter int RX_FIFO_DEPTH = MAC_RX_FIFO_BYTES
)(
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       hs_mode,
    input  wire logic       frame_mode,
    input  wire logic       bo_valid,
    input  wire logic [7:0] bo_data,
    input  wire logic       bo_last,
    input  wire logic       bo_err,
    output logic            bo_ready,
    output logic            bo_space_ok,
    output logic            bi_data_avail,
    input  wire logic       bi_start,
    output logic            bi_valid,
    output logic [7:0]      bi_data,
    output logic            bi_last,
    input  wire logic       bi_ready,
    input  wire logic       bi_ack,
    input  wire logic       bi_retry,
    output logic            mtx_valid,
    output logic [7:0]      mtx_data,
    output logic            mtx_last,
    input  wire logic       mtx_ready,
    input  wire logic       mrx_valid,
    input  wire logic [7:0] mrx_data,
    input  wire logic       mrx_last,
    input  wire logic       mrx_bad,
    output logic            mrx_ready
);
    generate
        if (TX_FIFO_DEPTH < 2048 || RX_FIFO_DEPTH < 2)
        begin : g_bad_params
            $error("ubf_bulk_path fifo depths too small");
        end
    endgenerate

    function automatic logic [15:0] step(input logic [15:0] a, input logic [15:0] n, input logic [15:0] size);
        logic [15:0] s;
        s = a + n;
        step = (s >= size) ? s - size : s;
    endfunction

    logic [7:0] sram [0:SRAM_BYTES-1];

    wire logic [15:0] blk_bytes = hs_mode ? HS_BLOCK_BYTES : FS_BLOCK_BYTES;

    // Bulk-out writer
    ubf_wr_type  bo_phase;
    logic [15:0] tx_wr;
    logic [15:0] tx_pkt_start;
    logic [15:0] tx_pend;
    logic [15:0] tx_cnt;
    logic [15:0] tx_add_q;
    logic        bo_in_pkt;
    logic        bo_single;

    wire logic [15:0] tx_free       = TX_REGION_BYTES - tx_cnt - tx_pend;
    wire logic        bo_pkt_single = bo_in_pkt ? bo_single : (frame_mode == MODE_SINGLE);
    wire logic        bo_take       = bo_valid && bo_ready;
    wire logic [15:0] bo_skip       = (!bo_in_pkt && bo_pkt_single) ? HDR_BYTES : 16'h0000;
    wire logic [15:0] bo_adv        = bo_skip + 16'h0001;
    wire logic [15:0] tx_len        = tx_pend - HDR_BYTES;
    wire logic        bo_len_lo     = bo_phase == WR_LEN_LO;
    wire logic        bo_len_hi     = bo_phase == WR_LEN_HI;
    wire logic        bo_flush      = bo_take && bo_last && bo_err;
    wire logic        bo_good_end   = bo_take && bo_last && !bo_err;
    wire logic [15:0] bo_addr       = bo_len_lo ? tx_pkt_start :
                                      bo_len_hi ? step(tx_pkt_start, 16'h0001, TX_REGION_BYTES) :
                                      step(tx_wr, bo_skip, TX_REGION_BYTES);
    wire logic [7:0]  bo_wdata      = bo_len_lo ? tx_len[7:0] : bo_len_hi ? tx_len[15:8] : bo_data;
    wire logic        bo_we         = (bo_take && !bo_flush) || bo_len_lo || bo_len_hi;
    wire logic [15:0] tx_add        = (bo_good_end && !bo_pkt_single) ? tx_pend + 16'h0001 :
                                      bo_len_hi ? tx_pend : 16'h0000;

    assign bo_ready    = (bo_phase == WR_DATA) && (tx_free >= SLOT_BYTES);
    assign bo_space_ok = !bo_in_pkt && (bo_phase == WR_DATA) && (tx_free >= blk_bytes + HDR_BYTES);

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            bo_phase     <= WR_DATA;
            tx_wr        <= 16'h0000;
            tx_pkt_start <= 16'h0000;
            tx_pend      <= 16'h0000;
            bo_in_pkt    <= 1'b0;
            bo_single    <= 1'b0;
        end
        else
        begin
            case (bo_phase)
                WR_LEN_LO: bo_phase <= WR_LEN_HI;
                WR_LEN_HI:
                begin
                    bo_phase     <= WR_DATA;
                    tx_pend      <= 16'h0000;
                    tx_pkt_start <= tx_wr;
                end
                WR_DATA:
                begin
                    if (bo_take)
                    begin
                        bo_in_pkt <= !bo_last;
                        bo_single <= bo_pkt_single;
                    end
                    if (bo_flush)
                    begin
                        tx_wr   <= tx_pkt_start;
                        tx_pend <= 16'h0000;
                    end
                    else if (bo_take)
                    begin
                        tx_wr   <= step(tx_wr, bo_adv, TX_REGION_BYTES);
                        tx_pend <= tx_pend + bo_adv;
                        if (bo_last && bo_pkt_single)
                            bo_phase <= WR_LEN_LO;
                        else if (bo_last)
                        begin
                            tx_pend      <= 16'h0000;
                            tx_pkt_start <= step(tx_wr, bo_adv, TX_REGION_BYTES);
                        end
                    end
                end
                default: bo_phase <= WR_DATA;
            endcase
        end
    end

    // Frame extractor toward the MAC transmit FIFO
    ubf_parse_type ex_ps;
    logic [15:0]   ex_rd;
    logic [15:0]   ex_rem;
    logic [7:0]    ex_byte;
    logic [1:0]    tx_frames;
    logic          txf_in_ready;
    logic          txf_out_valid;
    logic [8:0]    txf_out_data;

    // Bytes committed before this edge are already readable
    wire logic        tx_old_avail = (tx_cnt - tx_add_q) != 16'h0000;
    wire logic        ex_data_push = (ex_ps == PS_DATA) && tx_old_avail && txf_in_ready;
    wire logic        ex_hdr_take  = tx_old_avail && ((ex_ps == PS_HDR0) ||
                                     ((ex_ps == PS_HDR1) && (tx_frames < MAC_TX_MAX_FRAMES)));
    wire logic        ex_take      = ex_data_push || ex_hdr_take;
    wire logic        ex_last_push = ex_data_push && (ex_rem == 16'h0001);
    wire logic [15:0] ex_next      = ex_take ? step(ex_rd, 16'h0001, TX_REGION_BYTES) : ex_rd;
    wire logic        frames_ready = tx_frames != 2'h0;
    wire logic        mtx_pop_last = mtx_valid && mtx_ready && mtx_last;
    wire logic [15:0] next_tx_cnt  = tx_cnt + tx_add - {15'h0000, ex_take};

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ex_ps     <= PS_HDR0;
            ex_rd     <= 16'h0000;
            ex_rem    <= 16'h0000;
            tx_frames <= 2'h0;
            tx_cnt    <= 16'h0000;
            tx_add_q  <= 16'h0000;
        end
        else
        begin
            tx_cnt    <= next_tx_cnt;
            tx_add_q  <= tx_add;
            ex_rd     <= ex_next;
            tx_frames <= tx_frames + {1'b0, ex_last_push} - {1'b0, mtx_pop_last};
            if (ex_take)
            begin
                case (ex_ps)
                    PS_HDR0:
                    begin
                        ex_rem[7:0] <= ex_byte;
                        ex_ps       <= PS_HDR1;
                    end
                    PS_HDR1:
                    begin
                        ex_rem[15:8] <= ex_byte;
                        ex_ps        <= ({ex_byte, ex_rem[7:0]} == 16'h0000) ? PS_HDR0 : PS_DATA;
                    end
                    PS_DATA:
                    begin
                        ex_rem <= ex_rem - 16'h0001;
                        if (ex_rem == 16'h0001)
                            ex_ps <= PS_HDR0;
                    end
                    default: ex_ps <= PS_HDR0;
                endcase
            end
        end
    end

    ubf_fifo #(.WIDTH(9), .DEPTH(TX_FIFO_DEPTH)) u_tx_fifo (
        .clk                (clk),
        .rst_b              (rst_b),
        .in_valid           ((ex_ps == PS_DATA) && tx_old_avail),
        .in_data            ({ex_rem == 16'h0001, ex_byte}),
        .in_ready           (txf_in_ready),
        .out_valid          (txf_out_valid),
        .out_data           (txf_out_data),
        .out_ready_unused_n (),
        .out_ready          (mtx_ready && frames_ready)
    );

    assign mtx_valid = txf_out_valid && frames_ready;
    assign mtx_data  = txf_out_valid ? txf_out_data[7:0] : 8'h00;
    assign mtx_last  = txf_out_valid && txf_out_data[8];

    logic       rxf_out_valid;
    logic [9:0] rxf_out_data;
    logic       rxf_out_ready;

    ubf_fifo #(.WIDTH(10), .DEPTH(RX_FIFO_DEPTH)) u_rx_fifo (
        .clk                (clk),
        .rst_b              (rst_b),
        .in_valid           (mrx_valid),
        .in_data            ({mrx_bad, mrx_last, mrx_data}),
        .in_ready           (mrx_ready),
        .out_valid          (rxf_out_valid),
        .out_data           (rxf_out_data),
        .out_ready_unused_n (),
        .out_ready          (rxf_out_ready)
    );

    // Receive region writer, always length-prefixed
    ubf_wr_type  rw_phase;
    logic [15:0] rx_wr;
    logic [15:0] rx_fstart;
    logic [15:0] rx_pend;
    logic [15:0] rx_cnt;
    logic [15:0] rx_add_q;
    logic        rw_in_frame;

    wire logic [15:0] rx_free   = RX_REGION_BYTES - rx_cnt - rx_pend;
    wire logic        rw_take   = rxf_out_valid && rxf_out_ready;
    wire logic        rw_end    = rw_take && rxf_out_data[8];
    wire logic        rw_flush  = rw_end && rxf_out_data[9];
    wire logic [15:0] rw_skip   = rw_in_frame ? 16'h0000 : HDR_BYTES;
    wire logic [15:0] rw_adv    = rw_skip + 16'h0001;
    wire logic [15:0] rx_len    = rx_pend - HDR_BYTES;
    wire logic        rw_len_lo = rw_phase == WR_LEN_LO;
    wire logic        rw_len_hi = rw_phase == WR_LEN_HI;
    wire logic [15:0] rw_addr   = rw_len_lo ? rx_fstart :
                                  rw_len_hi ? step(rx_fstart, 16'h0001, RX_REGION_BYTES) :
                                  step(rx_wr, rw_skip, RX_REGION_BYTES);
    wire logic [7:0]  rw_wdata  = rw_len_lo ? rx_len[7:0] : rw_len_hi ? rx_len[15:8] : rxf_out_data[7:0];
    wire logic        rw_we     = (rw_take && !rw_flush) || rw_len_lo || rw_len_hi;
    wire logic [15:0] rx_add    = rw_len_hi ? rx_pend : 16'h0000;

    assign rxf_out_ready = (rw_phase == WR_DATA) && (rx_free >= SLOT_BYTES);

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rw_phase    <= WR_DATA;
            rx_wr       <= 16'h0000;
            rx_fstart   <= 16'h0000;
            rx_pend     <= 16'h0000;
            rw_in_frame <= 1'b0;
        end
        else
        begin
            case (rw_phase)
                WR_LEN_LO: rw_phase <= WR_LEN_HI;
                WR_LEN_HI:
                begin
                    rw_phase  <= WR_DATA;
                    rx_pend   <= 16'h0000;
                    rx_fstart <= rx_wr;
                end
                WR_DATA:
                begin
                    if (rw_take)
                        rw_in_frame <= !rxf_out_data[8];
                    if (rw_flush)
                    begin
                        rx_wr   <= rx_fstart;
                        rx_pend <= 16'h0000;
                    end
                    else if (rw_take)
                    begin
                        rx_wr   <= step(rx_wr, rw_adv, RX_REGION_BYTES);
                        rx_pend <= rx_pend + rw_adv;
                        if (rw_end)
                            rw_phase <= WR_LEN_LO;
                    end
                end
                default: rw_phase <= WR_DATA;
            endcase
        end
    end

    // Bulk-in packet builder
    ubf_pkt_type   bi_phase;
    ubf_parse_type bi_ps;
    ubf_parse_type bi_ps_save;
    logic [15:0]   bi_rem;
    logic [15:0]   bi_rem_save;
    logic [15:0]   rx_rd;
    logic [15:0]   rx_head;
    logic [15:0]   bi_fly;
    logic [15:0]   bi_cnt;
    logic          bi_single;

    wire logic [15:0] rx_unread    = rx_cnt - bi_fly;
    wire logic        rx_old_avail = (rx_unread - rx_add_q) != 16'h0000;
    wire logic        bi_sending   = (bi_phase == BI_SEND) && rx_old_avail;
    wire logic        bi_hide      = bi_single && (bi_ps != PS_DATA);
    wire logic        bi_emit      = bi_valid && bi_ready;
    wire logic        bi_take      = bi_emit || (bi_sending && bi_hide);
    wire logic        bi_ok        = (bi_phase == BI_WAIT) && bi_ack;
    wire logic [15:0] bi_next      = bi_take ? step(rx_rd, 16'h0001, RX_REGION_BYTES) : rx_rd;

    assign bi_data_avail = (bi_phase == BI_IDLE) && rx_old_avail;
    assign bi_valid      = bi_sending && !bi_hide;
    // block size, data end, or, in single-frame mode, frame end closes the packet
    assign bi_last       = bi_valid && ((bi_cnt + 16'h0001 == blk_bytes) || (rx_unread == 16'h0001) ||
                           (bi_single && (bi_rem == 16'h0001)));

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            bi_phase    <= BI_IDLE;
            bi_ps       <= PS_HDR0;
            bi_ps_save  <= PS_HDR0;
            bi_rem      <= 16'h0000;
            bi_rem_save <= 16'h0000;
            rx_rd       <= 16'h0000;
            rx_head     <= 16'h0000;
            bi_fly      <= 16'h0000;
            bi_cnt      <= 16'h0000;
            bi_single   <= 1'b0;
            rx_cnt      <= 16'h0000;
            rx_add_q    <= 16'h0000;
        end
        else
        begin
            rx_add_q <= rx_add;
            rx_cnt   <= rx_cnt + rx_add - (bi_ok ? bi_fly : 16'h0000);
            rx_rd    <= bi_next;
            if (bi_take)
            begin
                bi_fly <= bi_fly + 16'h0001;
                case (bi_ps)
                    PS_HDR0:
                    begin
                        bi_rem[7:0] <= bi_data;
                        bi_ps       <= PS_HDR1;
                    end
                    PS_HDR1:
                    begin
                        bi_rem[15:8] <= bi_data;
                        bi_ps        <= ({bi_data, bi_rem[7:0]} == 16'h0000) ? PS_HDR0 : PS_DATA;
                    end
                    PS_DATA:
                    begin
                        bi_rem <= bi_rem - 16'h0001;
                        if (bi_rem == 16'h0001)
                            bi_ps <= PS_HDR0;
                    end
                    default: bi_ps <= PS_HDR0;
                endcase
            end
            if (bi_emit)
                bi_cnt <= bi_cnt + 16'h0001;
            case (bi_phase)
                BI_IDLE:
                    if (bi_start && rx_old_avail)
                    begin
                        bi_phase    <= BI_SEND;
                        bi_single   <= frame_mode == MODE_SINGLE;
                        bi_cnt      <= 16'h0000;
                        bi_ps_save  <= bi_ps;
                        bi_rem_save <= bi_rem;
                    end
                BI_SEND:
                    if (bi_emit && bi_last)
                        bi_phase <= BI_WAIT;
                BI_WAIT:
                    if (bi_ack)
                    begin
                        bi_phase <= BI_IDLE;
                        rx_head  <= rx_rd;
                        bi_fly   <= 16'h0000;
                    end
                    // rewind to packet start for resend
                    else if (bi_retry)
                    begin
                        bi_phase <= BI_IDLE;
                        rx_rd    <= rx_head;
                        bi_fly   <= 16'h0000;
                        bi_ps    <= bi_ps_save;
                        bi_rem   <= bi_rem_save;
                    end
                default: bi_phase <= BI_IDLE;
            endcase
        end
    end

    // SRAM ports: one write and one read per region
    always_ff @(posedge clk)
    begin
        if (bo_we)
            sram[TX_BASE + bo_addr[14:0]] <= bo_wdata;
        if (rw_we)
            sram[RX_BASE + rw_addr[14:0]] <= rw_wdata;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ex_byte <= 8'h00;
            bi_data <= 8'h00;
        end
        else
        begin
            ex_byte <= sram[TX_BASE + ex_next[14:0]];
            bi_data <= sram[RX_BASE + bi_next[14:0]];
        end
    end
endmodule

// File: sim/ubf_mac_model.sv
`timescale 1ns/1ps
module ubf_mac_model (
    input  wire logic       clk,
    input  wire logic       mtx_valid,
    input  wire logic [7:0] mtx_data,
    input  wire logic       mtx_last,
    output logic            mtx_ready,
    output logic            mrx_valid,
    output logic [7:0]      mrx_data,
    output logic            mrx_last,
    output logic            mrx_bad,
    input  wire logic       mrx_ready
);
    logic [7:0] got[$];
    int         n_frames = 0;
    int         seed     = 32'h0222A340;
    initial {mtx_ready, mrx_valid, mrx_data, mrx_last, mrx_bad} = '0;
    always @(posedge clk)
    begin
        if (mtx_valid && mtx_ready)
        begin
            got.push_back(mtx_data);
            n_frames += int'(mtx_last);
        end
        mtx_ready <= 1'($random(seed));
    end
    task automatic send(input logic [7:0] f[$], input logic bad);
        foreach (f[i])
        begin
            mrx_valid <= 1'b1;
            mrx_data  <= f[i];
            mrx_last  <= (i == f.size() - 1);
            mrx_bad   <= bad;
            do @(posedge clk); while (mrx_ready !== 1'b1);
        end
        mrx_valid <= 1'b0;
        mrx_data  <= ~mrx_data;
        @(posedge clk);
    endtask
endmodule

// File: sim/ubf_bulk_path_chk.sv
`timescale 1ns/1ps
module ubf_bulk_path_chk (
    input wire logic       clk,
    input wire logic       rst_b,
    input wire logic       frame_mode,
    input wire logic       bo_valid,
    input wire logic       bo_last,
    input wire logic       bo_err,
    input wire logic       bo_ready,
    input wire logic       bi_data_avail,
    input wire logic       bi_start,
    input wire logic       bi_valid,
    input wire logic [7:0] bi_data,
    input wire logic       bi_last,
    input wire logic       bi_ready,
    input wire logic       bi_retry,
    input wire logic       mtx_valid,
    input wire logic [7:0] mtx_data,
    input wire logic       mtx_last,
    input wire logic       mtx_ready
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_mtx_hold: assert property (mtx_valid && !mtx_ready |=> mtx_valid && $stable({mtx_data, mtx_last}))
        else $error("mac byte changed before taken");
    a_bi_hold: assert property (bi_valid && !bi_ready |=> $stable(bi_data))
        else $error("bulk-in byte changed before taken");
    a_start_leaves: assert property (bi_start && bi_data_avail |=> !bi_data_avail)
        else $error("bulk-in start ignored");
    a_start_sends: assert property (bi_start && bi_data_avail |-> ##[1:4] bi_valid)
        else $error("bulk-in data late");
    a_len_stall: assert property (bo_valid && bo_ready && bo_last && !bo_err && frame_mode |=> !bo_ready [*2])
        else $error("no length write after frame");
    a_idle_quiet: assert property (bi_data_avail |-> !bi_valid)
        else $error("bulk-in data while idle");
    a_wait_ack: assert property (bi_valid && bi_ready && bi_last |=> !bi_valid && !bi_data_avail)
        else $error("packet ended without waiting");
    a_retry_again: assert property (bi_retry |=> bi_data_avail)
        else $error("retried data not offered");
endmodule
bind ubf_bulk_path ubf_bulk_path_chk i_ubf_bulk_path_chk (
    .clk(clk), .rst_b(rst_b), .frame_mode(frame_mode), .bo_valid(bo_valid), .bo_last(bo_last), .bo_err(bo_err),
    .bo_ready(bo_ready), .bi_data_avail(bi_data_avail), .bi_start(bi_start), .bi_valid(bi_valid),
    .bi_data(bi_data), .bi_last(bi_last), .bi_ready(bi_ready), .bi_retry(bi_retry), .mtx_valid(mtx_valid),
    .mtx_data(mtx_data), .mtx_last(mtx_last), .mtx_ready(mtx_ready)
);

// File: sim/ubf_bulk_path_bench.sv
`timescale 1ns/1ps
module ubf_bulk_path_bench
    import ubf_pkg::*;
;
    typedef logic [7:0] ubf_byteq_type[$];
    logic          clk, rst_b, hs_mode, frame_mode, bo_valid, bo_last, bo_err, bo_ready, bo_space_ok;
    logic          bi_data_avail, bi_start, bi_valid, bi_last, bi_ready, bi_ack, bi_retry;
    logic          mtx_valid, mtx_last, mtx_ready, mrx_valid, mrx_last, mrx_bad, mrx_ready;
    logic [7:0]    bo_data, bi_data, mtx_data, mrx_data;
    ubf_byteq_type q, p, e, r;
    int            n_errors = 0, n_compared = 0, cyc = 0, seed = 32'h0222A340;
    ubf_bulk_path i_ubf_bulk_path (.*);
    ubf_mac_model i_ubf_mac_model (.*);
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_sim;
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            n_errors++;
            end_sim();
        end
    end
    function automatic void rnd(int n);
        q = {};
        repeat (n) q.push_back(8'($random(seed)));
    endfunction
    function automatic ubf_byteq_type framed(ubf_byteq_type f);
        logic [15:0] n;
        n = 16'(f.size());
        return {n[7:0], n[15:8], f};
    endfunction
    task automatic cmp(input ubf_byteq_type a, input ubf_byteq_type b);
        check(a.size(), b.size());
        foreach (b[i]) check(a[i], b[i]);
    endtask
    task automatic bulk_out(input logic err);
        foreach (q[i])
        begin
            bo_valid <= 1'b1;
            bo_data  <= q[i];
            bo_last  <= (i == q.size() - 1);
            bo_err   <= err;
            do @(posedge clk); while (bo_ready !== 1'b1);
        end
        bo_valid <= 1'b0;
        @(posedge clk);
    endtask
    task automatic mac_wait;
        for (int t = 0; t < 3000 && i_ubf_mac_model.got.size() < e.size(); t++) @(posedge clk);
        cmp(i_ubf_mac_model.got, e);
        i_ubf_mac_model.got = {};
    endtask
    task automatic bulk_in(input logic retry);
        r = {};
        for (int t = 0; t < 500 && bi_data_avail !== 1'b1; t++) @(posedge clk);
        bi_start <= 1'b1;
        @(posedge clk);
        bi_start <= 1'b0;
        for (int t = 0; t < 2000; t++)
        begin
            bi_ready <= 1'($random(seed));
            @(posedge clk);
            if (bi_valid === 1'b1 && bi_ready === 1'b1)
            begin
                r.push_back(bi_data);
                if (bi_last === 1'b1) break;
            end
        end
        bi_ready <= 1'b0;
        bi_retry <= retry;
        bi_ack   <= !retry;
        @(posedge clk);
        {bi_retry, bi_ack} <= 2'b00;
    endtask
    initial
    begin
        {rst_b, bo_valid, bo_last, bo_err, bi_start, bi_ready, bi_ack, bi_retry} = '0;
        {hs_mode, frame_mode, bo_data} = '0;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        check({bo_space_ok, bi_data_avail}, 2'b10);
        frame_mode <= MODE_SINGLE;
        rnd(9);
        bulk_out(1'b1);
        rnd(60);
        e = q;
        bulk_out(1'b0);
        mac_wait();
        frame_mode <= MODE_MULTI;
        rnd(5);
        p = q;
        rnd(7);
        e = {p, q};
        q = {framed(p), 8'h00, 8'h00, framed(q)};
        bulk_out(1'b0);
        mac_wait();
        check(i_ubf_mac_model.n_frames, 3);
        frame_mode <= MODE_SINGLE;
        rnd(10);
        i_ubf_mac_model.send(q, 1'b1);
        rnd(70);
        e = q;
        i_ubf_mac_model.send(q, 1'b0);
        bulk_in(1'b1);
        cmp(r, e[0:FS_BLOCK_BYTES-1]);
        bulk_in(1'b0);
        cmp(r, e[0:FS_BLOCK_BYTES-1]);
        bulk_in(1'b0);
        cmp(r, e[FS_BLOCK_BYTES:69]);
        hs_mode <= 1'b1;
        frame_mode <= MODE_MULTI;
        rnd(20);
        i_ubf_mac_model.send(q, 1'b0);
        bulk_in(1'b0);
        cmp(r, framed(q));
        repeat (2) @(posedge clk);
        check(bi_data_avail, 1'b0);
        end_sim();
    end
endmodule
